// [hw/branch_pkg.sv]
package branch_pkg;
   localparam int          WORD_W        = 32;
   localparam int          INSN_W        = 16;
   localparam int          OPC_MSB       = 15;
   localparam int          OPC_LSB       = 8;
   localparam int          ZERO_BIT_POS  = 7;
   localparam int          LOW_MSB       = 6;
   localparam int          LOW_LSB       = 1;
   localparam int          SIGN_POS      = 0;
   localparam int          SIGN_COPIES   = 25;
   localparam int          INSN_BYTES    = 2;
   localparam logic [31:0] PC_RESET      = 32'h0000_0000;
   localparam logic        MODE_RESET    = 1'b0;
   localparam logic [3:0]  FLAGS_RESET   = 4'h0;

   typedef enum logic [7:0] {
      OPC_EQUAL         = 8'hF2,
      OPC_NOT_EQUAL     = 8'hF3,
      OPC_NO_CARRY      = 8'hF5,
      OPC_HIGHER_THAN   = 8'hF7,
      OPC_NEGATIVE      = 8'hF8,
      OPC_GREATER_EQUAL = 8'hF9,
      OPC_LESS_EQUAL    = 8'hFA,
      OPC_GREATER_THAN  = 8'hFB
   } branch_opc_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01
   } exec_state_t;
endpackage

// [hw/branch_if.sv]
`timescale 1ns/10ps
interface branch_if;
   logic [15:0] insn;
   logic        zero_flag;
   logic        neg_flag;
   logic        carry_flag;
   logic        is_branch;
   logic        taken;
   logic [31:0] disp;
   modport decode (input insn, zero_flag, neg_flag, carry_flag,
                   output is_branch, taken, disp);
   modport core   (output insn, zero_flag, neg_flag, carry_flag,
                   input is_branch, taken, disp);
endinterface

// [hw/branch_cond_decode.sv]
`timescale 1ns/10ps
module branch_cond_decode
   import branch_pkg::*;
(
   branch_if.decode bus
);
   logic [7:0] opc;

   always_comb begin
      opc = bus.insn[OPC_MSB:OPC_LSB];
      bus.disp = {{SIGN_COPIES{bus.insn[SIGN_POS]}}, bus.insn[LOW_MSB:LOW_LSB], 1'b0};
      bus.is_branch = 1'b1;
      bus.taken = 1'b0;
      case (opc)
         OPC_EQUAL:         bus.taken = bus.zero_flag;
         OPC_GREATER_EQUAL: bus.taken = !bus.neg_flag;
         OPC_GREATER_THAN:  bus.taken = !bus.neg_flag && !bus.zero_flag;
         OPC_NO_CARRY:      bus.taken = !bus.carry_flag;
         OPC_HIGHER_THAN:   bus.taken = !bus.carry_flag && !bus.zero_flag;
         OPC_LESS_EQUAL:    bus.taken = bus.neg_flag || bus.zero_flag;
         OPC_NEGATIVE:      bus.taken = bus.neg_flag;
         OPC_NOT_EQUAL:     bus.taken = !bus.zero_flag;
         default:           bus.is_branch = 1'b0;
      endcase
      // Bit 7 must be zero or the word is not this format
      if (bus.insn[ZERO_BIT_POS]) begin
         bus.is_branch = 1'b0;
         bus.taken = 1'b0;
      end
   end
endmodule

// [hw/short_conditional_branch_unit.sv]
// Functional notes
// - Displacement is 25 sign copies, the low offset field, then a zero: even, -128 to 126.
// - The displacement adds to the address of the byte after the branch word.
// - A taken branch loads the target into the PC, clears cache mode and fetches there.
// - A taken branch leaves zero, negative, carry and overflow flags unchanged.
// - A branch not taken keeps cache mode and flags and continues in sequence.
// - Opcode F2 is taken only when zero is one.
// - Opcode F9 is taken only when negative is zero.
// - Opcode FB is taken only when negative and zero are both zero.
// - Opcode F5 is taken only when carry is zero.
// - Opcode F7 is taken only when carry and zero are both zero.
// - Opcode FA is taken when negative or zero is one.
// - Opcode F8 is taken only when negative is one.
// - Opcode F3 is taken only when zero is zero.
`timescale 1ns/10ps
module short_conditional_branch_unit
   import branch_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        insn_valid,
   input  wire logic [15:0] insn_word,
   input  wire logic [3:0]  flags_in,
   input  wire logic        flags_load,
   input  wire logic        cache_mode_set,
   output logic             insn_done,
   output logic             branch_taken,
   output logic             not_branch,
   output logic [31:0]      pc,
   output logic [31:0]      fetch_addr,
   output logic             fetch_redirect,
   output logic             cache_mode,
   output logic [3:0]       flags
);
   // Flag order in flags: {zero, neg, carry, overflow}
   branch_if    dec_bus ();
   exec_state_t state_reg;
   logic [31:0] pc_reg;
   logic [31:0] seq_addr;
   logic [31:0] target;
   logic        cache_mode_reg;
   logic [3:0]  flags_reg;
   logic        done_reg;
   logic        taken_reg;
   logic        not_branch_reg;
   logic        redirect_reg;
   logic        exec;

   branch_cond_decode u_dec (
      .bus (dec_bus.decode)
   );

   assign dec_bus.insn       = insn_word;
   assign dec_bus.zero_flag  = flags_reg[3];
   assign dec_bus.neg_flag   = flags_reg[2];
   assign dec_bus.carry_flag = flags_reg[1];

   assign exec     = (state_reg == ST_IDLE) && insn_valid;
   assign seq_addr = pc_reg + 32'(INSN_BYTES);
   assign target   = seq_addr + dec_bus.disp;

   // One instruction per two cycles keeps the flags stable while deciding
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: if (insn_valid) state_reg <= ST_EXEC;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pc_reg <= PC_RESET;
      end else if (exec && dec_bus.is_branch && dec_bus.taken) begin
         pc_reg <= target;
      end else if (exec) begin
         pc_reg <= seq_addr;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cache_mode_reg <= MODE_RESET;
      end else if (exec && dec_bus.is_branch && dec_bus.taken) begin
         cache_mode_reg <= 1'b0;
      end else if (cache_mode_set) begin
         cache_mode_reg <= 1'b1;
      end
   end

   // Flags only change by external load, never by a branch
   always_ff @(posedge clk) begin
      if (!nrst) begin
         flags_reg <= FLAGS_RESET;
      end else if (flags_load && !exec) begin
         flags_reg <= flags_in;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_reg       <= 1'b0;
         taken_reg      <= 1'b0;
         not_branch_reg <= 1'b0;
         redirect_reg   <= 1'b0;
      end else begin
         done_reg       <= exec;
         taken_reg      <= exec && dec_bus.is_branch && dec_bus.taken;
         not_branch_reg <= exec && !dec_bus.is_branch;
         redirect_reg   <= exec && dec_bus.is_branch && dec_bus.taken;
      end
   end

   assign insn_done      = done_reg;
   assign branch_taken   = taken_reg;
   assign not_branch     = not_branch_reg;
   assign pc             = pc_reg;
   assign fetch_addr     = pc_reg;
   assign fetch_redirect = redirect_reg;
   assign cache_mode     = cache_mode_reg;
   assign flags          = flags_reg;

   property p_target;
      @(posedge clk) disable iff (!nrst)
      exec && dec_bus.is_branch && dec_bus.taken |=> pc == $past(pc) + 32'h2 + $past(dec_bus.disp);
   endproperty
   a_target: assert property (p_target) else $error("taken target wrong");

   property p_seq;
      @(posedge clk) disable iff (!nrst)
      exec && !(dec_bus.is_branch && dec_bus.taken) |=> pc == $past(pc) + 32'h2;
   endproperty
   a_seq: assert property (p_seq) else $error("sequential pc wrong");

   property p_mode_clear;
      @(posedge clk) disable iff (!nrst)
      exec && dec_bus.is_branch && dec_bus.taken |=> !cache_mode && fetch_redirect;
   endproperty
   a_mode_clear: assert property (p_mode_clear) else $error("mode not cleared");

   property p_flags_kept;
      @(posedge clk) disable iff (!nrst)
      exec |=> $stable(flags);
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("flags changed by branch");

   property p_mode_kept;
      @(posedge clk) disable iff (!nrst)
      exec && !dec_bus.taken && !cache_mode_set |=> $stable(cache_mode);
   endproperty
   a_mode_kept: assert property (p_mode_kept) else $error("mode changed");

   property p_disp;
      @(posedge clk) disable iff (!nrst)
      dec_bus.disp[0] == 1'b0 && dec_bus.disp[31:7] == {25{insn_word[0]}};
   endproperty
   a_disp: assert property (p_disp) else $error("displacement form wrong");

   property p_eq;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:7] == 9'h1E4 |-> dec_bus.taken == flags[3];
   endproperty
   a_eq: assert property (p_eq) else $error("equal cond wrong");

   property p_gt;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:7] == 9'h1F6 |-> dec_bus.taken == (!flags[2] && !flags[3]);
   endproperty
   a_gt: assert property (p_gt) else $error("greater cond wrong");

   property p_ht;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:7] == 9'h1EE |-> dec_bus.taken == (!flags[1] && !flags[3]);
   endproperty
   a_ht: assert property (p_ht) else $error("higher cond wrong");

   property p_bit7;
      @(posedge clk) disable iff (!nrst)
      insn_word[7] |-> !dec_bus.is_branch;
   endproperty
   a_bit7: assert property (p_bit7) else $error("bit7 set accepted");

   property p_ge;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:7] == 9'h1F2 |-> dec_bus.taken == !flags[2];
   endproperty
   a_ge: assert property (p_ge) else $error("greater-or-equal cond wrong");

   property p_nc;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:7] == 9'h1EA |-> dec_bus.taken == !flags[1];
   endproperty
   a_nc: assert property (p_nc) else $error("no-carry cond wrong");

   property p_le;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:7] == 9'h1F4 |-> dec_bus.taken == (flags[2] || flags[3]);
   endproperty
   a_le: assert property (p_le) else $error("less-or-equal cond wrong");

   property p_neg;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:7] == 9'h1F0 |-> dec_bus.taken == flags[2];
   endproperty
   a_neg: assert property (p_neg) else $error("negative cond wrong");

   property p_ne;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:7] == 9'h1E6 |-> dec_bus.taken == !flags[3];
   endproperty
   a_ne: assert property (p_ne) else $error("not-equal cond wrong");

   property p_disp_low;
      @(posedge clk) disable iff (!nrst)
      dec_bus.disp[6:1] == insn_word[6:1];
   endproperty
   a_disp_low: assert property (p_disp_low) else $error("offset field misplaced");

   property p_disp_range;
      @(posedge clk) disable iff (!nrst)
      $signed(dec_bus.disp) >= -128 && $signed(dec_bus.disp) <= 126;
   endproperty
   a_disp_range: assert property (p_disp_range) else $error("displacement out of range");

   property p_high_nibble;
      @(posedge clk) disable iff (!nrst)
      insn_word[15:12] != 4'hF |-> !dec_bus.is_branch;
   endproperty
   a_high_nibble: assert property (p_high_nibble) else $error("foreign word decoded");

   property p_unknown_not_taken;
      @(posedge clk) disable iff (!nrst)
      !dec_bus.is_branch |-> !dec_bus.taken;
   endproperty
   a_unknown_not_taken: assert property (p_unknown_not_taken) else $error("unknown taken");

   property p_done;
      @(posedge clk) disable iff (!nrst)
      exec |=> insn_done;
   endproperty
   a_done: assert property (p_done) else $error("done pulse missing");

   property p_done_no_exec;
      @(posedge clk) disable iff (!nrst)
      insn_done |-> !exec;
   endproperty
   a_done_no_exec: assert property (p_done_no_exec) else $error("word taken too soon");

   property p_redirect_eq;
      @(posedge clk) disable iff (!nrst)
      fetch_redirect == branch_taken;
   endproperty
   a_redirect_eq: assert property (p_redirect_eq) else $error("redirect differs");

   property p_fetch_pc;
      @(posedge clk) disable iff (!nrst)
      fetch_addr == pc;
   endproperty
   a_fetch_pc: assert property (p_fetch_pc) else $error("fetch address differs");

   property p_taken_done;
      @(posedge clk) disable iff (!nrst)
      branch_taken |-> insn_done && !not_branch;
   endproperty
   a_taken_done: assert property (p_taken_done) else $error("taken pulse alone");

   property p_not_branch;
      @(posedge clk) disable iff (!nrst)
      exec && !dec_bus.is_branch |=> not_branch && !branch_taken;
   endproperty
   a_not_branch: assert property (p_not_branch) else $error("not-branch pulse wrong");

   property p_pc_hold;
      @(posedge clk) disable iff (!nrst)
      !exec |=> $stable(pc);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved while idle");

   property p_flags_hold;
      @(posedge clk) disable iff (!nrst)
      !flags_load |=> $stable(flags);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags moved");

   property p_mode_hold;
      @(posedge clk) disable iff (!nrst)
      !(exec && dec_bus.is_branch && dec_bus.taken) && !cache_mode_set |=> $stable(cache_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved");

   property p_redirect_mode;
      @(posedge clk) disable iff (!nrst)
      fetch_redirect |-> !cache_mode;
   endproperty
   a_redirect_mode: assert property (p_redirect_mode) else $error("mode kept on redirect");

   property p_seq_no_redirect;
      @(posedge clk) disable iff (!nrst)
      exec && !dec_bus.taken |=> !fetch_redirect && !branch_taken;
   endproperty
   a_seq_no_redirect: assert property (p_seq_no_redirect) else $error("false redirect");

   property p_exec_gap;
      @(posedge clk) disable iff (!nrst)
      exec |=> !exec;
   endproperty
   a_exec_gap: assert property (p_exec_gap) else $error("two words back to back");
endmodule

// [testbench/short_conditional_branch_unit_tb.sv]
`timescale 1ns/10ps
module short_conditional_branch_unit_tb;
   import branch_pkg::*;
   logic        clk;
   logic        nrst;
   logic        insn_valid;
   logic [15:0] insn_word;
   logic [3:0]  flags_in;
   logic        flags_load;
   logic        cache_mode_set;
   logic        insn_done;
   logic        branch_taken;
   logic        not_branch;
   logic [31:0] pc;
   logic [31:0] fetch_addr;
   logic        fetch_redirect;
   logic        cache_mode;
   logic [3:0]  flags;
   logic [31:0] pc_exp;
   int          mismatches;
   int          checks_done;
   int          cycles;
   logic [7:0]  opcs [8] = '{8'hF2, 8'hF3, 8'hF5, 8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'hFB};

   short_conditional_branch_unit uut (.clk(clk), .nrst(nrst), .insn_valid(insn_valid),
      .insn_word(insn_word), .flags_in(flags_in), .flags_load(flags_load),
      .cache_mode_set(cache_mode_set), .insn_done(insn_done), .branch_taken(branch_taken),
      .not_branch(not_branch), .pc(pc), .fetch_addr(fetch_addr),
      .fetch_redirect(fetch_redirect), .cache_mode(cache_mode), .flags(flags));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Hang guard, well above the ~400 cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         complete_run;
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Returns {known, taken}; flags are {Z,N,C,V}
   function automatic logic [1:0] expect_of(logic [15:0] w, logic [3:0] f);
      logic z;
      logic n;
      logic c;
      z = f[3];
      n = f[2];
      c = f[1];
      if (w[7]) return 2'b00;
      case (w[15:8])
         8'hF2: return {1'b1, z};
         8'hF3: return {1'b1, !z};
         8'hF5: return {1'b1, !c};
         8'hF7: return {1'b1, !c && !z};
         8'hF8: return {1'b1, n};
         8'hF9: return {1'b1, !n};
         8'hFA: return {1'b1, n || z};
         8'hFB: return {1'b1, !n && !z};
         default: return 2'b00;
      endcase
   endfunction

   // Sets cache mode and flags, then runs one word while a refused flag load is held up
   task run_word(input logic [15:0] w, input logic [3:0] f);
      logic [1:0]  e;
      logic [31:0] disp;
      e = expect_of(w, f);
      disp = {{25{w[0]}}, w[6:1], 1'b0};
      @(negedge clk);
      flags_in = f;
      flags_load = 1'b1;
      cache_mode_set = 1'b1;
      @(negedge clk);
      cache_mode_set = 1'b0;
      insn_valid = 1'b1;
      insn_word = w;
      flags_in = ~f;
      @(negedge clk);
      insn_valid = 1'b0;
      flags_load = 1'b0;
      pc_exp = e[0] ? pc_exp + 32'h2 + disp : pc_exp + 32'h2;
      check(insn_done, 1'b1);
      check(branch_taken, e[0]);
      check(fetch_redirect, e[0]);
      check(not_branch, !e[1]);
      check(pc, pc_exp);
      check(fetch_addr, pc_exp);
      check(cache_mode, !e[0]);
      check(flags, f);
   endtask

   // Reset in mid-run must drop the PC, mode and flags back
   task reset_again;
      @(negedge clk);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      pc_exp = PC_RESET;
      check(pc, PC_RESET);
      check(cache_mode, MODE_RESET);
      check(flags, FLAGS_RESET);
      check(insn_done, 1'b0);
   endtask

   initial begin
      nrst = 1'b0;
      insn_valid = 1'b0;
      insn_word = 16'h0000;
      flags_in = 4'h0;
      flags_load = 1'b0;
      cache_mode_set = 1'b0;
      pc_exp = PC_RESET;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      check(pc, 32'h0000_0000);
      check(cache_mode, 1'b0);
      check(flags, 4'h0);
      for (int i = 0; i < 8; i++) begin
         for (int f = 0; f < 16; f++) begin
            // Extremes of the offset range on the first and last flag patterns
            if (f == 0) run_word({opcs[i], 8'h7E}, 4'(f));
            else if (f == 15) run_word({opcs[i], 8'h01}, 4'(f));
            else run_word({opcs[i], 1'b0, 6'((i * 7 + f * 5) % 64), 1'((i + f) % 2)}, 4'(f));
         end
      end
      run_word(16'hF43A, 4'h2);
      run_word(16'hF2C4, 4'h8);
      reset_again;
      run_word(16'h127E, 4'h8);
      complete_run;
   end
endmodule
